// File: design/tsc_map.vh
// Register offsets, field positions, clock source codes, reset values and interrupt bits for the timer block
`ifndef TSC_MAP_VH
`define TSC_MAP_VH
`define TSC_OFF_STATUS_CONTROL 12'h000
`define TSC_OFF_COUNT_HIGH 12'h004
`define TSC_OFF_COUNT_LOW 12'h008
`define TSC_OFF_MODULO_HIGH 12'h00C
`define TSC_OFF_MODULO_LOW 12'h010
`define TSC_OFF_IRQ_STATUS 12'h014
`define TSC_OFF_IRQ_MASK 12'h018
`define TSC_BIT_OVF 7
`define TSC_BIT_OVF_IE 6
`define TSC_BIT_CENTER 5
`define TSC_CLOCK_SOURCE_SELECT_HI 4
`define TSC_CLOCK_SOURCE_SELECT_LO 3
`define TSC_PS_HI 2
`define TSC_PS_LO 0
`define TSC_CLOCK_SOURCE_SELECT_NONE 2'h0
`define TSC_CLOCK_SOURCE_SELECT_SYS 2'h1
`define TSC_CLOCK_SOURCE_SELECT_FIXED 2'h2
`define TSC_CLOCK_SOURCE_SELECT_EXT 2'h3
`define TSC_SC_RESET 8'h00
`define TSC_MOD_RESET 16'hFFFF
`define TSC_IRQ_BITS 2
`define TSC_IRQ_OVF 0
`define TSC_IRQ_CLR 1
`endif

// File: design/tsc_timer_status_counter.v
// Status/control, prescaler and counter-access logic of a 16-bit timer with an APB slave
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
`include "tsc_map.vh"

module tsc_timer_status_counter #(
	parameter WIDTH = 16,
	parameter PS_BITS = 3
) (
	input wire clock,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire fixedClockTick,
	input wire externalClockTick,
	input wire debugHaltMode,
	output reg timerIrq,
	output reg overflowIrq
);
	// Status/control fields
	reg overflowFlag_reg;
	reg overflowIrqEnable_reg;
	reg centerAlignedSelect_reg;
	reg [1:0] clockSourceSelect_reg;
	reg [PS_BITS-1:0] prescaleSelect_reg;
	reg clearArmed_reg;
	// Counter and modulo
	reg [WIDTH-1:0] count_reg;
	reg [WIDTH-1:0] modulo_reg;
	reg countDown_reg;
	reg [6:0] prescaleCount_reg;
	// Read coherency
	reg [WIDTH-1:0] latchValue_reg;
	reg latchHigh_reg;
	reg latchLow_reg;
	// Interrupt status and mask
	reg [`TSC_IRQ_BITS-1:0] irqStatus_reg;
	reg [`TSC_IRQ_BITS-1:0] irqMask_reg;

	wire access = psel && penable;
	wire wrEn = access && pready && pwrite && pstrb[0];
	wire rdEn = access && !pwrite;
	wire offSc = paddr == `TSC_OFF_STATUS_CONTROL;
	wire offCh = paddr == `TSC_OFF_COUNT_HIGH;
	wire offCl = paddr == `TSC_OFF_COUNT_LOW;
	wire offMh = paddr == `TSC_OFF_MODULO_HIGH;
	wire offMl = paddr == `TSC_OFF_MODULO_LOW;
	wire offIs = paddr == `TSC_OFF_IRQ_STATUS;
	wire offIm = paddr == `TSC_OFF_IRQ_MASK;
	wire mapped = offSc | offCh | offCl | offMh | offMl | offIs | offIm;
	wire scWrite = wrEn && offSc;
	wire cntWrite = wrEn && (offCh || offCl);

	// Source tick; none selected means the counter never advances
	reg sourceTick;
	always @* begin
		case (clockSourceSelect_reg)
			`TSC_CLOCK_SOURCE_SELECT_NONE: sourceTick = 1'b0;
			`TSC_CLOCK_SOURCE_SELECT_SYS: sourceTick = 1'b1;
			`TSC_CLOCK_SOURCE_SELECT_FIXED: sourceTick = fixedClockTick;
			`TSC_CLOCK_SOURCE_SELECT_EXT: sourceTick = externalClockTick;
			default: sourceTick = 1'b0;
		endcase
	end

	// Prescaler reads the registered field, so a new value acts one cycle later
	wire [6:0] prescaleMask = (7'h01 << prescaleSelect_reg) - 7'h01;
	wire prescaleTick = ((prescaleCount_reg & prescaleMask) == prescaleMask);
	wire countTick = sourceTick && prescaleTick && !debugHaltMode;

	// Overflow event: up mode wraps at modulo, up-down mode turns at zero
	wire atModulo = count_reg == modulo_reg;
	wire atZero = count_reg == {WIDTH{1'b0}};
	wire overflowEvent = countTick && !cntWrite &&
		(centerAlignedSelect_reg ? (countDown_reg && (atZero || atModulo)) : atModulo);

	// Clear sequence: zero written to bit 7 while armed, and no new overflow
	wire clearRequest = scWrite && clearArmed_reg && !pwdata[`TSC_BIT_OVF];

	wire [7:0] scRead = {overflowFlag_reg, overflowIrqEnable_reg, centerAlignedSelect_reg,
		clockSourceSelect_reg, prescaleSelect_reg};
	wire latched = latchHigh_reg || latchLow_reg;
	wire [WIDTH-1:0] readCount = latched ? latchValue_reg : count_reg;
	wire [`TSC_IRQ_BITS-1:0] irqEvents = {clearRequest && !overflowEvent, overflowEvent};

	// One wait state: answer in the cycle after the access phase opens
	always @(posedge clock) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	// Prescaler runs on the selected source; frozen in debug halt
	always @(posedge clock) begin
		if (rst) begin
			prescaleCount_reg <= 7'h00;
		end else begin
			if (cntWrite) begin
				prescaleCount_reg <= 7'h00;
			end else if (sourceTick && !debugHaltMode) begin
				prescaleCount_reg <= prescaleTick ? 7'h00 : prescaleCount_reg + 7'h01;
			end

		end
	end

	// Counter
	always @(posedge clock) begin
		if (rst) begin
			count_reg <= {WIDTH{1'b0}};
			countDown_reg <= 1'b0;
		end else begin
			if (cntWrite) begin
				count_reg <= {WIDTH{1'b0}};
				countDown_reg <= 1'b0;
			end else if (countTick) begin
				if (!centerAlignedSelect_reg) begin
					count_reg <= atModulo ? {WIDTH{1'b0}} : count_reg + 1'b1;
					countDown_reg <= 1'b0;
				end else if (countDown_reg) begin
					if (atZero || atModulo) begin
						countDown_reg <= 1'b0;
						count_reg <= atModulo ? count_reg : count_reg + 1'b1;
					end else begin
						count_reg <= count_reg - 1'b1;
					end
				end else if (atModulo) begin
					countDown_reg <= 1'b1;
					count_reg <= count_reg - 1'b1;
				end else begin
					count_reg <= count_reg + 1'b1;
				end
			end

		end
	end

	// Overflow flag: a new event wins over a pending clear
	always @(posedge clock) begin
		if (rst) begin
			overflowFlag_reg <= 1'b0;
			clearArmed_reg <= 1'b0;
		end else begin
			if (overflowEvent) begin
				overflowFlag_reg <= 1'b1;
				clearArmed_reg <= 1'b0;
			end else if (clearRequest) begin
				overflowFlag_reg <= 1'b0;
				clearArmed_reg <= 1'b0;
			end else if (access && pready && offSc && overflowFlag_reg) begin
				clearArmed_reg <= !pwrite;
			end

		end
	end

	// Control fields take the write on the answer edge
	always @(posedge clock) begin
		if (rst) begin
			overflowIrqEnable_reg <= 1'b0;
			centerAlignedSelect_reg <= 1'b0;
			clockSourceSelect_reg <= `TSC_CLOCK_SOURCE_SELECT_NONE;
			prescaleSelect_reg <= {PS_BITS{1'b0}};
		end else begin
			if (scWrite && pready) begin
				overflowIrqEnable_reg <= pwdata[`TSC_BIT_OVF_IE];
				centerAlignedSelect_reg <= pwdata[`TSC_BIT_CENTER];
				clockSourceSelect_reg <= pwdata[`TSC_CLOCK_SOURCE_SELECT_HI:`TSC_CLOCK_SOURCE_SELECT_LO];
				prescaleSelect_reg <= pwdata[`TSC_PS_HI:`TSC_PS_LO];
			end

		end
	end

	// Modulo written directly, no write buffer
	always @(posedge clock) begin
		if (rst) begin
			modulo_reg <= `TSC_MOD_RESET;
			irqMask_reg <= {`TSC_IRQ_BITS{1'b0}};
		end else begin
			if (wrEn && pready && offMh) begin
				modulo_reg <= {pwdata[7:0], modulo_reg[7:0]};
			end
			if (wrEn && pready && offMl) begin
				modulo_reg <= {modulo_reg[15:8], pwdata[7:0]};
			end
			if (wrEn && pready && offIm) begin
				irqMask_reg <= pwdata[`TSC_IRQ_BITS-1:0];
			end

		end
	end

	// Sticky status: set wins over write-one-to-clear
	always @(posedge clock) begin
		if (rst) begin
			irqStatus_reg <= {`TSC_IRQ_BITS{1'b0}};
		end else begin
			irqStatus_reg <= irqEvents |
				(irqStatus_reg & ~((wrEn && pready && offIs) ?
				pwdata[`TSC_IRQ_BITS-1:0] : {`TSC_IRQ_BITS{1'b0}}));

		end
	end

	// Coherency latch; reads leave it as is during debug halt, status/control and count writes still clear it
	always @(posedge clock) begin
		if (rst) begin
			latchValue_reg <= {WIDTH{1'b0}};
			latchHigh_reg <= 1'b0;
			latchLow_reg <= 1'b0;
		end else begin
			if ((scWrite || cntWrite) && pready) begin
				latchHigh_reg <= 1'b0;
				latchLow_reg <= 1'b0;
			end else if (rdEn && pready && !debugHaltMode) begin
				if (offCh) begin
					if (latchLow_reg) begin
						latchLow_reg <= 1'b0;
					end else begin
						latchHigh_reg <= 1'b1;
						latchValue_reg <= count_reg;
					end
				end else if (offCl) begin
					if (latchHigh_reg) begin
						latchHigh_reg <= 1'b0;
					end else begin
						latchLow_reg <= 1'b1;
						latchValue_reg <= count_reg;
					end
				end
			end

		end
	end

	// Read data staged on the edge that raises pready, zero otherwise
	always @(posedge clock) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= 32'h0000_0000;
			if (rdEn && !pready) begin
				if (offSc) begin
					prdata <= {24'h00_0000, scRead};
				end else if (offCh) begin
					prdata <= {24'h00_0000, readCount[15:8]};
				end else if (offCl) begin
					prdata <= {24'h00_0000, readCount[7:0]};
				end else if (offMh) begin
					prdata <= {24'h00_0000, modulo_reg[15:8]};
				end else if (offMl) begin
					prdata <= {24'h00_0000, modulo_reg[7:0]};
				end else if (offIs) begin
					prdata <= {30'h0000_0000, irqStatus_reg};
				end else if (offIm) begin
					prdata <= {30'h0000_0000, irqMask_reg};
				end
			end

		end
	end

	// Interrupt outputs registered, one cycle behind the flags
	always @(posedge clock) begin
		if (rst) begin
			overflowIrq <= 1'b0;
			timerIrq <= 1'b0;
		end else begin
			overflowIrq <= overflowFlag_reg && overflowIrqEnable_reg;
			timerIrq <= |(irqStatus_reg & irqMask_reg);
		end
	end
endmodule // tsc_timer_status_counter

// File: test/tb_timer_status_counter_access.sv
// Self-checking bench for the timer status and counter block
`timescale 1ns/100ps
module tb_timer_status_counter_access;
	reg clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, debugHaltMode = 0;
	reg fixedClockTick = 0, externalClockTick = 0;
	reg [1:0] ph = 2'h0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0000_0000;
	wire [31:0] prdata;
	wire pready, pslverr, timerIrq, overflowIrq;
	integer mismatches = 0, checked = 0, i, c, t;
	reg [31:0] rd;
	reg err;
	tsc_timer_status_counter uut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hF), .prdata, .pready, .pslverr, .fixedClockTick, .externalClockTick,
		.debugHaltMode, .timerIrq, .overflowIrq);
	always #50 clock = ~clock;
	// Tick sources at a quarter of the clock rate, the fastest allowed
	always @(posedge clock) begin
		ph <= ph + 2'h1;
		fixedClockTick <= ph == 2'h0;
		externalClockTick <= ph == 2'h2;
	end
	task chk(input [32:0] got, input [32:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task xf(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge clock);
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clock);
			penable <= 1;
			@(posedge clock);
			while (pready !== 1'b1) @(posedge clock);
			rd = prdata;
			err = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask
	// Count for 512 cycles from zero, stop, read back; one count of slack
	task meas(input [7:0] sc, input integer exp);
		begin
			xf(1, 12'h008, $urandom);
			xf(1, 12'h000, sc);
			repeat (508) @(posedge clock);
			xf(1, 12'h000, 32'h0000_0000);
			xf(0, 12'h004, 32'h0000_0000);
			t = rd[7:0] << 8;
			xf(0, 12'h008, 32'h0000_0000);
			t = t | rd[7:0];
			chk(t >= exp - 1 && t <= exp + 1, 33'h0_0000_0001);
		end
	endtask
	task end_of_test;
		begin
			$display("checked=%0d mismatches=%0d", checked, mismatches);
			if (mismatches == 0 && checked > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	initial begin
		repeat (60000) @(posedge clock);
		mismatches = mismatches + 1;
		end_of_test;
	end
	initial begin
		i = $urandom(32'h9b0c);
		repeat (12) @(posedge clock);
		rst <= 0;
		xf(0, 12'h000, 32'h0000_0000);
		chk(rd, 33'h0_0000_0000);
		xf(0, 12'hFFC, 32'h0000_0000);
		chk({err, rd}, 33'h1_0000_0000);
		for (c = 0; c < 4; c = c + 1)
			for (i = 0; i < 8; i = i + 1)
				meas(c * 8 + i, c == 0 ? 0 : (c == 1 ? 512 : 128) >> i);
		xf(1, 12'h00C, 32'h0000_0001);
		xf(1, 12'h010, 32'h0000_0000);
		meas(8'h28, 0);
		meas(8'h08, 255);
		xf(0, 12'h000, 32'h0000_0000);
		chk(rd, 33'h0_0000_0080);
		xf(1, 12'h000, 32'h0000_00C0);
		xf(0, 12'h000, 32'h0000_0000);
		chk({overflowIrq, rd}, 33'h1_0000_00C0);
		xf(1, 12'h000, 32'h0000_0040);
		xf(0, 12'h000, 32'h0000_0000);
		chk({overflowIrq, rd}, 33'h0_0000_0040);
		xf(1, 12'h018, 32'h0000_0002);
		xf(0, 12'h014, 32'h0000_0000);
		chk({timerIrq, rd}, 33'h1_0000_0003);
		xf(1, 12'h014, 32'h0000_0003);
		xf(0, 12'h014, 32'h0000_0000);
		chk({timerIrq, rd}, 33'h0_0000_0000);
		xf(1, 12'h000, 32'h0000_0008);
		repeat (300) @(posedge clock);
		xf(0, 12'h000, 32'h0000_0000);
		repeat (300) @(posedge clock);
		xf(1, 12'h000, 32'h0000_0008);
		xf(0, 12'h000, 32'h0000_0000);
		chk(rd, 33'h0_0000_0088);
		xf(1, 12'h010, 32'h0000_00FF);
		xf(1, 12'h00C, 32'h0000_00FF);
		xf(1, 12'h004, $urandom);
		repeat (476) @(posedge clock);
		xf(0, 12'h008, 32'h0000_0000);
		repeat (60) @(posedge clock);
		debugHaltMode <= 1;
		xf(0, 12'h008, 32'h0000_0000);
		t = rd;
		repeat (100) @(posedge clock);
		xf(0, 12'h008, 32'h0000_0000);
		chk(rd, t);
		debugHaltMode <= 0;
		xf(0, 12'h004, 32'h0000_0000);
		chk(rd, 33'h0_0000_0001);
		end_of_test;
	end
endmodule // tb_timer_status_counter_access

// File: test/tsc_chk.sv
// Port checker for the timer status and counter block
`timescale 1ns/100ps
module tsc_chk (
	input wire clock,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire debugHaltMode,
	input wire overflowIrq,
	input wire timerIrq
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
	a_err_unmapped: assert property (pready && $past(paddr) > 12'h018 |-> pslverr)
		else $error("no slverr");
	a_err_ready: assert property (pslverr |-> pready && prdata == 0) else $error("bad slverr");
	a_idle_data: assert property (!pready |-> prdata == 32'h0000_0000) else $error("data");
	a_irq_fall: assert property ($fell(overflowIrq) |-> $past(pwrite && pready, 2))
		else $error("irq fell");
	a_halt_frozen: assert property ($rose(overflowIrq) && $past(debugHaltMode)
		&& $past(debugHaltMode, 2) && $past(debugHaltMode, 3) |-> $past(pwrite && pready, 2))
		else $error("halt overflow");
	a_reset_quiet: assert property (@(posedge clock) disable iff (1'b0)
		rst |=> !pready && !overflowIrq && !timerIrq) else $error("reset");
	cover property (pslverr);
	cover property ($rose(overflowIrq));
	cover property ($rose(timerIrq));
endmodule // tsc_chk
bind tsc_timer_status_counter tsc_chk chk (.clock, .rst, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .debugHaltMode, .overflowIrq, .timerIrq);
